//--- bench/flash_read_accelerator_bench.sv
`timescale 1ns/10ps
// self-checking bench for the flash read path
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; $display("ERROR %0t got %0h expected %0h", $time, g, e); end end
module flash_read_accelerator_bench;
	localparam logic [31:0] ONES = 32'hFFFF_FFFF;
	localparam logic [2:0] WD = fra_pkg::HSIZE_WORD;
	localparam logic [2:0] HF = fra_pkg::HSIZE_HALF;
	logic ref_clk, rst_b, hsel, hwrite, hready, prefetch_enable, prefetch_busy;
	logic [31:0] haddr, hrdata, a, cur, ln;
	logic [1:0] htrans, hresp, flash_wait_count;
	logic [2:0] hsize, sz;
	int failures, checked, busy_seen, w;
	fra_top i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hsize(hsize), .hwrite(hwrite), .hready_in(hready),
		.flash_wait_count(flash_wait_count), .prefetch_enable(prefetch_enable),
		.hrdata(hrdata), .hready(hready), .hresp(hresp), .prefetch_busy(prefetch_busy));
	fra_cpu_model i_cpu (.ref_clk(ref_clk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hsize(hsize), .hwrite(hwrite));
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (prefetch_busy === 1'b1) busy_seen++;
	end
	// kind 0 current hit, 1 prefetch hit, 2 array miss, 3 ignored access
	function automatic int exp_lat(input int kind, input int wc);
		case (kind)
			0: return 2;
			1: return 3;
			2: return 5 + wc;
			default: return 1;
		endcase
	endfunction
	task automatic acc(input logic [31:0] ad, input logic [2:0] s, input logic wr, input int el,
			input logic [31:0] ed);
		int lat;
		logic [31:0] d;
		i_cpu.xfer(ad, s, wr, lat, d);
		`CHK(lat, el)
		`CHK(d, ed)
	endtask
	// let any speculative fetch finish so later latencies are not stretched
	task automatic settle();
		int n;
		n = 0;
		repeat (3) @(posedge ref_clk);
		while (prefetch_busy !== 1'b0 && n < 40) begin
			@(posedge ref_clk);
			n++;
		end
		`CHK(n < 40, 1'b1)
		#1;
	endtask
	task automatic conclude();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		failures = 0;
		checked = 0;
		busy_seen = 0;
		void'($urandom(37815));
		rst_b = 1'b0;
		prefetch_enable = 1'b0;
		flash_wait_count = 2'h3;
		repeat (20) @(posedge ref_clk);
		#1;
		`CHK({hready, hresp, hrdata, prefetch_busy}, {1'b1, 2'h0, 32'h0, 1'b0})
		rst_b = 1'b1;
		acc(32'h2000_0000, WD, 1'b0, exp_lat(3, 0), 32'h0);
		acc(32'h0801_0000, WD, 1'b0, exp_lat(3, 0), 32'h0);
		acc(fra_pkg::MAIN_BASE, WD, 1'b1, exp_lat(3, 0), 32'h0);
		acc(fra_pkg::MAIN_LAST - 32'h3, WD, 1'b0, exp_lat(2, 0), ONES);
		for (w = 0; w < 3; w++) begin
			// clock never changes here, so wait-count ordering is kept trivially
			flash_wait_count = w[1:0];
			a = fra_pkg::MAIN_BASE + 32'h100 * (w + 1);
			acc(a, WD, 1'b0, exp_lat(2, w), ONES);
			acc(a + 32'h4, WD, 1'b0, exp_lat(0, w), ONES);
			acc(a + 32'h2, HF, 1'b0, exp_lat(0, w), ONES);
			acc(a + 32'h8, WD, 1'b0, exp_lat(2, w), ONES);
		end
		acc(fra_pkg::BOOT_BASE - 32'h4, WD, 1'b0, exp_lat(3, 2), ONES);
		acc(fra_pkg::BOOT_BASE, WD, 1'b0, exp_lat(2, 2), ONES);
		acc(fra_pkg::BOOT_LAST - 32'h3, WD, 1'b0, exp_lat(2, 2), ONES);
		acc(fra_pkg::OPT_BASE, HF, 1'b0, exp_lat(2, 2), ONES);
		acc(fra_pkg::OPT_LAST - 32'h3, WD, 1'b0, exp_lat(2, 2), ONES);
		acc(fra_pkg::OPT_LAST + 32'h1, WD, 1'b0, exp_lat(3, 2), ONES);
		settle();
		`CHK(busy_seen, 0)
		prefetch_enable = 1'b1;
		a = fra_pkg::MAIN_BASE + 32'h400;
		acc(a, WD, 1'b0, exp_lat(2, 2), ONES);
		acc(a + 32'h6, HF, 1'b0, exp_lat(0, 2), ONES);
		settle();
		`CHK(busy_seen > 0, 1'b1)
		acc(a + 32'h8, WD, 1'b0, exp_lat(1, 2), ONES);
		acc(a + 32'hC, WD, 1'b0, exp_lat(0, 2), ONES);
		settle();
		acc(fra_pkg::MAIN_BASE + 32'h8000, WD, 1'b0, exp_lat(2, 2), ONES);
		settle();
		acc(a + 32'h10, WD, 1'b0, exp_lat(2, 2), ONES);
		settle();
		prefetch_enable = 1'b0;
		cur = ONES;
		for (int i = 0; i < 60; i++) begin
			w = $urandom % 3;
			flash_wait_count = w[1:0];
			ln = 32'h0800_F000 + 32'h8 * ($urandom % 4);
			sz = ($urandom % 2) ? WD : HF;
			a = ln + ((sz == WD) ? 32'h4 * ($urandom % 2) : 32'h2 * ($urandom % 4));
			acc(a, sz, 1'b0, exp_lat((ln == cur) ? 0 : 2, w), ONES);
			cur = ln;
		end
		conclude();
	end
endmodule

//--- bench/fra_cpu_model.sv
`timescale 1ns/10ps
// processor-side AHB read master for the flash read path
module fra_cpu_model (
	input wire logic ref_clk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic [2:0] hsize,
	output logic hwrite
);
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hsize = fra_pkg::HSIZE_WORD;
		hwrite = 1'b0;
	end
	// lat counts edges after the address phase until ready is seen high
	task automatic xfer(input logic [31:0] a, input logic [2:0] sz, input logic wr,
			output int lat, output logic [31:0] d);
		int n;
		n = 0;
		hsel = 1'b1;
		haddr = a;
		htrans = fra_pkg::HTRANS_NONSEQ;
		hsize = sz;
		hwrite = wr;
		do begin
			@(posedge ref_clk);
			n++;
		end while (hready !== 1'b1 && n < 60);
		#1;
		hsel = 1'b0;
		htrans = 2'h0;
		hwrite = 1'b0;
		// released address shows a toggled pattern so a stale value cannot pass
		haddr = ~a;
		lat = 0;
		do begin
			@(posedge ref_clk);
			lat++;
			d = hrdata;
		end while (hready !== 1'b1 && lat < 60);
		#1;
	endtask
endmodule

//--- common/fra_pkg.sv
// shared constants for the flash read accelerator
package fra_pkg;
	localparam int ADDR_W = 32;
	localparam logic [31:0] MAIN_BASE = 32'h0800_0000;
	localparam int MAIN_PAGES = 64;
	localparam int PAGE_BYTES = 1024;
	localparam logic [31:0] MAIN_LAST = 32'h0800_FFFF;
	localparam logic [31:0] BOOT_BASE = 32'h1FFF_EC00;
	localparam logic [31:0] BOOT_LAST = 32'h1FFF_F7FF;
	localparam logic [31:0] OPT_BASE = 32'h1FFF_F800;
	localparam logic [31:0] OPT_LAST = 32'h1FFF_F80F;
	localparam int LINE_W = 64;
	localparam int LINE_IDX_W = 14;
	localparam int LINE_LSB = 3;
	localparam int WAIT_W = 2;
	localparam logic [1:0] WAIT_RESET = 2'h0;
	localparam logic [1:0] WAIT_MAX = 2'h2;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [2:0] HSIZE_HALF = 3'h1;
	localparam logic [1:0] HRESP_OKAY = 2'h0;
	// line index spaces: main 0..8191, boot 8192+, option 8576+
	localparam logic [13:0] BOOT_IDX_BASE = 14'h2000;
	localparam logic [13:0] OPT_IDX_BASE = 14'h2180;
	localparam int ARRAY_LINES = 8578;
endpackage

//--- rtl/fra_array.sv
`timescale 1ns/10ps
// flash array model: 64-bit lines, registered read data, erased value all ones
module fra_array #(
	parameter int LINES = fra_pkg::ARRAY_LINES,
	parameter int IDX_W = fra_pkg::LINE_IDX_W
) (
	input wire logic ref_clk,
	input wire logic rd_en,
	input wire logic [IDX_W-1:0] rd_idx,
	output logic [fra_pkg::LINE_W-1:0] rd_data
);
	logic [fra_pkg::LINE_W-1:0] mem [LINES];

	initial begin
		if (LINES > (1 << IDX_W)) begin
			$error("fra_array: LINES exceeds index range");
		end
		for (int i = 0; i < LINES; i++) begin
			mem[i] = '1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rd_en) begin
			rd_data <= mem[rd_idx];
		end
	end
endmodule

//--- rtl/fra_line_buf.sv
`timescale 1ns/10ps
// one 64-bit line buffer with tag and valid flag
module fra_line_buf #(
	parameter int IDX_W = fra_pkg::LINE_IDX_W
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic load,
	input wire logic clear,
	input wire logic [IDX_W-1:0] load_idx,
	input wire logic [fra_pkg::LINE_W-1:0] load_data,
	output logic valid_q,
	output logic [IDX_W-1:0] idx_q,
	output logic [fra_pkg::LINE_W-1:0] data_q
);
	// load wins over clear so a line fetched in the discard cycle survives
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			valid_q <= 1'b0;
		end else if (load) begin
			valid_q <= 1'b1;
		end else if (clear) begin
			valid_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			idx_q <= '0;
			data_q <= '0;
		end else if (load) begin
			idx_q <= load_idx;
			data_q <= load_data;
		end
	end
endmodule

//--- rtl/fra_top.sv
`timescale 1ns/10ps
// flash read path: AHB slave, wait states, current and prefetch line buffers
module fra_top (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic [2:0] hsize,
	input wire logic hwrite,
	input wire logic hready_in,
	input wire logic [fra_pkg::WAIT_W-1:0] flash_wait_count,
	input wire logic prefetch_enable,
	output logic [31:0] hrdata,
	output logic hready,
	output logic [1:0] hresp,
	output logic prefetch_busy
);
	localparam int IW = fra_pkg::LINE_IDX_W;

	// elaboration guard: every region's lines must fit the shared line index
	initial begin
		if (fra_pkg::ARRAY_LINES > (1 << IW)) begin
			$error("fra_top: line index too narrow for the array");
		end
	end

	typedef enum logic [1:0] {FRA_IDLE, FRA_WAIT, FRA_DATA} fra_arr_t;

	// wait count is a level from the same clock's config logic, no sync needed
	logic [fra_pkg::WAIT_W-1:0] ws_q;
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ws_q <= fra_pkg::WAIT_RESET;
		end else if (flash_wait_count <= fra_pkg::WAIT_MAX) begin
			ws_q <= flash_wait_count;
		end
	end

	// address decode into line index spaces
	logic in_main, in_boot, in_opt, mapped;
	logic [IW-1:0] req_idx;
	logic [31:0] off;
	always_comb begin
		in_main = haddr >= fra_pkg::MAIN_BASE && haddr <= fra_pkg::MAIN_LAST;
		in_boot = haddr >= fra_pkg::BOOT_BASE && haddr <= fra_pkg::BOOT_LAST;
		in_opt = haddr >= fra_pkg::OPT_BASE && haddr <= fra_pkg::OPT_LAST;
		mapped = in_main || in_boot || in_opt;
		req_idx = '0;
		off = '0;
		if (in_main) begin
			off = haddr - fra_pkg::MAIN_BASE;
			req_idx = off[fra_pkg::LINE_LSB +: IW];
		end else if (in_boot) begin
			off = haddr - fra_pkg::BOOT_BASE;
			req_idx = IW'(off[31:fra_pkg::LINE_LSB]) + fra_pkg::BOOT_IDX_BASE;
		end else if (in_opt) begin
			off = haddr - fra_pkg::OPT_BASE;
			req_idx = IW'(off[31:fra_pkg::LINE_LSB]) + fra_pkg::OPT_IDX_BASE;
		end
	end

	// writes are not served here: no program or erase path exists at all
	logic take;
	assign take = hsel && hready_in && hready && !hwrite && mapped
		&& (htrans == fra_pkg::HTRANS_NONSEQ || htrans == fra_pkg::HTRANS_SEQ);

	logic cur_v, pf_v;
	logic [IW-1:0] cur_idx, pf_idx;
	logic [63:0] cur_data, pf_data, arr_data;

	// pending request held across the data phase
	logic pend_q;
	logic [IW-1:0] pend_idx_q;
	logic [2:0] pend_off_q;
	logic [2:0] pend_size_q;

	fra_arr_t arr_q;
	logic [1:0] wcnt_q;
	logic [IW-1:0] arr_idx_q;
	logic arr_is_pf_q;

	logic hit_cur, hit_pf, pf_inflight_hit;
	assign hit_cur = cur_v && cur_idx == pend_idx_q;
	assign hit_pf = pf_v && pf_idx == pend_idx_q;
	assign pf_inflight_hit = arr_q != FRA_IDLE && arr_is_pf_q && arr_idx_q == pend_idx_q;

	logic arr_done;
	assign arr_done = arr_q == FRA_DATA;

	// array start: demand miss has priority over prefetch
	logic start_dem, start_pf, pf_want;
	logic [IW-1:0] nxt_idx;
	assign nxt_idx = cur_idx + IW'(1);
	assign pf_want = prefetch_enable && cur_v && !(pf_v && pf_idx == nxt_idx)
		&& nxt_idx != fra_pkg::BOOT_IDX_BASE && !(pend_q && !hit_cur);
	assign start_dem = arr_q == FRA_IDLE && pend_q && !hit_cur && !hit_pf;
	assign start_pf = arr_q == FRA_IDLE && !start_dem && pf_want
		&& int'(nxt_idx) < fra_pkg::ARRAY_LINES;

	logic arr_start;
	logic [IW-1:0] arr_start_idx;
	assign arr_start = start_dem || start_pf;
	assign arr_start_idx = start_dem ? pend_idx_q : nxt_idx;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			arr_q <= FRA_IDLE;
			wcnt_q <= '0;
			arr_idx_q <= '0;
			arr_is_pf_q <= 1'b0;
		end else begin
			case (arr_q)
				FRA_IDLE: begin
					if (arr_start) begin
						arr_idx_q <= arr_start_idx;
						arr_is_pf_q <= start_pf;
						wcnt_q <= ws_q;
						arr_q <= FRA_WAIT;
					end
				end
				FRA_WAIT: begin
					if (wcnt_q == '0) begin
						arr_q <= FRA_DATA;
					end else begin
						wcnt_q <= wcnt_q - 2'h1;
					end
				end
				FRA_DATA: arr_q <= FRA_IDLE;
				default: arr_q <= FRA_IDLE;
			endcase
		end
	end

	// array read issued on the last wait cycle; data registered in the memory
	logic arr_rd;
	assign arr_rd = arr_q == FRA_WAIT && wcnt_q == '0;

	fra_array u_array (
		.ref_clk(ref_clk),
		.rd_en(arr_rd),
		.rd_idx(arr_idx_q),
		.rd_data(arr_data)
	);

	// demand line goes to current buffer; prefetched line to prefetch buffer
	logic cur_load, pf_load, pf_clear;
	assign cur_load = (arr_done && !arr_is_pf_q) || (pend_q && !hit_cur && hit_pf);
	assign pf_load = arr_done && arr_is_pf_q;
	assign pf_clear = start_dem || (pend_q && !hit_cur && hit_pf);

	fra_line_buf u_cur (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.load(cur_load),
		.clear(1'b0),
		.load_idx(arr_done && !arr_is_pf_q ? arr_idx_q : pf_idx),
		.load_data(arr_done && !arr_is_pf_q ? arr_data : pf_data),
		.valid_q(cur_v),
		.idx_q(cur_idx),
		.data_q(cur_data)
	);

	fra_line_buf u_pf (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.load(pf_load),
		.clear(pf_clear),
		.load_idx(arr_idx_q),
		.load_data(arr_data),
		.valid_q(pf_v),
		.idx_q(pf_idx),
		.data_q(pf_data)
	);

	// a pending request completes once its line sits in the current buffer
	logic serve;
	assign serve = pend_q && hit_cur;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pend_q <= 1'b0;
			pend_idx_q <= '0;
			pend_off_q <= '0;
			pend_size_q <= '0;
		end else if (take) begin
			pend_q <= 1'b1;
			pend_idx_q <= req_idx;
			pend_off_q <= off[2:0];
			pend_size_q <= hsize;
		end else if (serve) begin
			pend_q <= 1'b0;
		end
	end

	// hready falls with the taken address and rises with the served data
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			hready <= 1'b1;
		end else if (take) begin
			hready <= 1'b0;
		end else if (serve) begin
			hready <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			hrdata <= '0;
		end else if (serve) begin
			hrdata <= pend_off_q[2] ? cur_data[63:32] : cur_data[31:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			hresp <= fra_pkg::HRESP_OKAY;
			prefetch_busy <= 1'b0;
		end else begin
			hresp <= fra_pkg::HRESP_OKAY;
			prefetch_busy <= start_pf || (arr_q != FRA_IDLE && arr_is_pf_q && !arr_done);
		end
	end

	// helper: cycles since a request was taken
	logic [3:0] stall_cnt_q;
	always_ff @(posedge ref_clk) begin
		if (!rst_b || take) begin
			stall_cnt_q <= '0;
		end else if (!hready && stall_cnt_q != 4'hF) begin
			stall_cnt_q <= stall_cnt_q + 4'h1;
		end
	end

	no_pf_fetch_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!prefetch_enable |-> !start_pf)
		else $error("prefetch fetch started while disabled");
	ws_reset_a: assert property (@(posedge ref_clk)
		!rst_b |=> ws_q == 2'h0)
		else $error("wait count not zero after reset");
	wait_len_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		arr_q == FRA_IDLE && arr_start ##1 1'b1 |-> ##[1:3] arr_done)
		else $error("array access exceeded wait bound");
	wait_exact_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(arr_q == FRA_IDLE && arr_start && ws_q == 2'h2)
		|=> arr_q == FRA_WAIT ##1 arr_q == FRA_WAIT ##1 arr_q == FRA_WAIT ##1 arr_done)
		else $error("two wait states not honoured");
	cur_hit_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		pend_q && hit_cur && !hready |=> hready)
		else $error("current buffer hit not served next cycle");
	ready_low_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		take |=> !hready)
		else $error("ready not lowered for taken read");
	stall_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		stall_cnt_q < 4'hC)
		else $error("read stalled too long");
	miss_discard_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		start_dem && !pf_load |=> !pf_v)
		else $error("stale prefetch line kept after miss");
	pf_promote_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		pend_q && !hit_cur && hit_pf && arr_q == FRA_IDLE |=> cur_v && !arr_done ##1 hready)
		else $error("prefetch hit did not avoid array access");
	fill_cur_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		arr_done && !arr_is_pf_q |=> cur_v && cur_idx == $past(arr_idx_q))
		else $error("current buffer not loaded from array");
	// answer path: ready rises and data changes only when a pending read is served
	ready_rise_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(hready) |-> $past(serve))
		else $error("ready rose without a served read");
	data_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!serve |=> $stable(hrdata))
		else $error("read data changed without a served read");
	resp_okay_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		hresp == fra_pkg::HRESP_OKAY)
		else $error("response not okay");
	write_ignored_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		hsel && hwrite && hready |=> hready)
		else $error("write access stalled the bus");
	pf_busy_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		start_pf |=> prefetch_busy)
		else $error("prefetch start not reported busy");
	inflight_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		pend_q && !hit_cur && pf_inflight_hit && arr_done |=> hit_pf)
		else $error("in-flight prefetch line not taken as hit");
endmodule
